// *** include/pws_pkg.sv ***
// Package of offsets, reset values and state codes for the wake status bank
package pws_pkg;

   // Register data width and bus address width
   localparam int unsigned REG_W = 8;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned PIN_N = 16;

   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_STS4 = 6'h07;
   localparam logic [5:0] IDX_STS5 = 6'h08;
   localparam logic [5:0] IDX_RSVD = 6'h09;
   localparam logic [5:0] IDX_EN4 = 6'h0C;
   localparam logic [5:0] IDX_EN5 = 6'h0D;
   localparam logic [5:0] IDX_GEN = 6'h0E;
   localparam logic [5:0] IDX_IMSK4 = 6'h0F;
   localparam logic [5:0] IDX_IMSK5 = 6'h10;

   // Field position of the global wake enable
   localparam int unsigned GEN_BIT = 0;

   // Values after reset
   localparam logic [7:0] RST_STS = 8'h00;
   localparam logic [7:0] RST_EN = 8'h00;
   localparam logic [7:0] RST_IMSK = 8'h00;
   localparam logic RST_GEN = 1'b0;
   localparam logic [15:0] RST_PINS = 16'h0000;
   localparam logic [31:0] RST_RDATA = 32'h0000_0000;

   // Bus slave states, one-hot
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RESP = 2'b10
   } pws_apb_state_type;

endpackage

// *** rtl/pws_bank.sv ***
// Wake status bank with enables, interrupt mask and APB slave
//
// Function
// - Status records event regardless of any enable
// - Event sets status bit, held until cleared
// - Status survives main-supply, soft and hard reset
// - Writing one to bits 7..0 clears them
// - Writing zero leaves the status bit unchanged
// - Fourth register maps port3, port4, port6 pins
// - Fifth register maps port5 pins 0..7
// - Reserved offset reads zero, ignores writes
// - Wake output low when status, enable, global set
`timescale 1ns/1ps

module pws_bank
   import pws_pkg::*;
(
   input wire logic clk, // 20 MHz clock
   input wire logic sys_rst, // Main/soft/hard reset, sync high
   input wire logic vtr_por, // Standby-well power-on reset, sync high
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB direction, high for write
   input wire logic [ADDR_W-1:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   input wire logic [3:0] pstrb, // APB byte strobes
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire logic port3_pin0, // Wake source pin
   input wire logic port3_pin1, // Wake source pin
   input wire logic port3_pin2, // Wake source pin
   input wire logic port3_pin3, // Wake source pin
   input wire logic port4_pin1, // Wake source pin
   input wire logic port4_pin3, // Wake source pin
   input wire logic port6_pin0, // Wake source pin
   input wire logic port6_pin1, // Wake source pin
   input wire logic port5_pin0, // Wake source pin
   input wire logic port5_pin1, // Wake source pin
   input wire logic port5_pin2, // Wake source pin
   input wire logic port5_pin3, // Wake source pin
   input wire logic port5_pin4, // Wake source pin
   input wire logic port5_pin5, // Wake source pin
   input wire logic port5_pin6, // Wake source pin
   input wire logic port5_pin7, // Wake source pin
   output logic wake_request_out_n, // Wake request, active low
   output logic irq // Interrupt, high while unmasked status set
);

////////////////////////////////////////////////////////////////////////////
// Pin synchroniser

   logic [PIN_N-1:0] pins_raw;
   logic [PIN_N-1:0] pin_s1_ff;
   logic [PIN_N-1:0] pin_s2_ff;
   logic [PIN_N-1:0] nxt_pin_s1;
   logic [PIN_N-1:0] nxt_pin_s2;
   logic [7:0] ev4;
   logic [7:0] ev5;

   // Gather pins in status bit order
   assign pins_raw = {port5_pin7, port5_pin6, port5_pin5, port5_pin4,
                      port5_pin3, port5_pin2, port5_pin1, port5_pin0,
                      port6_pin1, port6_pin0, port4_pin3, port4_pin1,
                      port3_pin3, port3_pin2, port3_pin1, port3_pin0};

   // Two-stage capture; only the second stage feeds logic
   always_comb begin
      nxt_pin_s1 = pins_raw;
      nxt_pin_s2 = pin_s1_ff;
      if (vtr_por) begin
         nxt_pin_s1 = RST_PINS;
         nxt_pin_s2 = RST_PINS;
      end
   end

   always_ff @(posedge clk) begin
      pin_s1_ff <= nxt_pin_s1;
      pin_s2_ff <= nxt_pin_s2;
   end

   // Event vectors per register
   assign ev4 = pin_s2_ff[7:0];
   assign ev5 = pin_s2_ff[15:8];

////////////////////////////////////////////////////////////////////////////
// APB slave

   pws_apb_state_type state_ff;
   pws_apb_state_type nxt_state;
   logic pready_ff;
   logic nxt_pready;
   logic pslverr_ff;
   logic nxt_pslverr;
   logic [31:0] prdata_ff;
   logic [31:0] nxt_prdata;
   logic [5:0] idx;
   logic aligned;
   logic mapped;
   logic [7:0] rd_val;
   logic fire;
   logic wr_fire;
   logic [7:0] wdat;

   assign idx = paddr[7:2];
   assign aligned = (paddr[1:0] == 2'b00);
   assign fire = psel & penable & pready_ff;
   assign wr_fire = fire & pwrite & pstrb[0] & mapped;
   assign wdat = pwdata[7:0];

   logic [7:0] sts4_ff;
   logic [7:0] sts5_ff;
   logic [7:0] en4_ff;
   logic [7:0] en5_ff;
   logic [7:0] imsk4_ff;
   logic [7:0] imsk5_ff;
   logic gen_ff;

   // Read mux and address decode
   always_comb begin
      rd_val = 8'h00;
      mapped = aligned;
      case (idx)
         IDX_STS4: rd_val = sts4_ff;
         IDX_STS5: rd_val = sts5_ff;
         IDX_RSVD: rd_val = 8'h00;
         IDX_EN4: rd_val = en4_ff;
         IDX_EN5: rd_val = en5_ff;
         IDX_GEN: rd_val = {7'h00, gen_ff};
         IDX_IMSK4: rd_val = imsk4_ff;
         IDX_IMSK5: rd_val = imsk5_ff;
         default: mapped = 1'b0;
      endcase
   end

   // Answer one cycle into the access phase
   always_comb begin
      nxt_state = state_ff;
      nxt_pready = 1'b0;
      nxt_pslverr = 1'b0;
      nxt_prdata = RST_RDATA;
      case (state_ff)
         ST_IDLE: begin
            if (psel && penable) begin
               nxt_state = ST_RESP;
               nxt_pready = 1'b1;
               nxt_pslverr = ~mapped;
               // Refused addresses read zero, aligned or not
               nxt_prdata = {24'h000000, mapped ? rd_val : 8'h00};
            end
         end
         ST_RESP: nxt_state = ST_IDLE;
         default: nxt_state = ST_IDLE;
      endcase
      if (sys_rst) begin
         nxt_state = ST_IDLE;
         nxt_pready = 1'b0;
         nxt_pslverr = 1'b0;
         nxt_prdata = RST_RDATA;
      end
   end

   always_ff @(posedge clk) begin
      state_ff <= nxt_state;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff <= nxt_prdata;
   end

   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign prdata = prdata_ff;

////////////////////////////////////////////////////////////////////////////
// Status, enable and mask registers

   logic [7:0] clr4;
   logic [7:0] clr5;
   logic [7:0] nxt_sts4;
   logic [7:0] nxt_sts5;
   logic [7:0] nxt_en4;
   logic [7:0] nxt_en5;
   logic [7:0] nxt_imsk4;
   logic [7:0] nxt_imsk5;
   logic nxt_gen;

   // Clear masks from write-one data; zeros clear nothing
   assign clr4 = (wr_fire && idx == IDX_STS4) ? wdat : 8'h00;
   assign clr5 = (wr_fire && idx == IDX_STS5) ? wdat : 8'h00;

   // Sticky set beats clear; sys_rst does not touch this state
   always_comb begin
      nxt_sts4 = (sts4_ff & ~clr4) | ev4;
      nxt_sts5 = (sts5_ff & ~clr5) | ev5;
      nxt_en4 = en4_ff;
      nxt_en5 = en5_ff;
      nxt_imsk4 = imsk4_ff;
      nxt_imsk5 = imsk5_ff;
      nxt_gen = gen_ff;
      if (wr_fire) begin
         case (idx)
            IDX_EN4: nxt_en4 = wdat;
            IDX_EN5: nxt_en5 = wdat;
            IDX_GEN: nxt_gen = wdat[GEN_BIT];
            IDX_IMSK4: nxt_imsk4 = wdat;
            IDX_IMSK5: nxt_imsk5 = wdat;
            default: nxt_gen = gen_ff; // Status and reserved: no store
         endcase
      end
      if (vtr_por) begin
         nxt_sts4 = RST_STS;
         nxt_sts5 = RST_STS;
         nxt_en4 = RST_EN;
         nxt_en5 = RST_EN;
         nxt_imsk4 = RST_IMSK;
         nxt_imsk5 = RST_IMSK;
         nxt_gen = RST_GEN;
      end
   end

   always_ff @(posedge clk) begin
      sts4_ff <= nxt_sts4;
      sts5_ff <= nxt_sts5;
      en4_ff <= nxt_en4;
      en5_ff <= nxt_en5;
      imsk4_ff <= nxt_imsk4;
      imsk5_ff <= nxt_imsk5;
      gen_ff <= nxt_gen;
   end

////////////////////////////////////////////////////////////////////////////
// Wake request and interrupt outputs

   logic wake_n_ff;
   logic nxt_wake_n;
   logic irq_ff;
   logic nxt_irq;

   // Wake drives low on any enabled, set source with global enable
   always_comb begin
      nxt_wake_n = ~(gen_ff &
                     (|({sts5_ff, sts4_ff} & {en5_ff, en4_ff})));
      nxt_irq = |({sts5_ff, sts4_ff} & {imsk5_ff, imsk4_ff});
      if (vtr_por) begin
         nxt_wake_n = 1'b1;
         nxt_irq = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      wake_n_ff <= nxt_wake_n;
      irq_ff <= nxt_irq;
   end

   assign wake_request_out_n = wake_n_ff;
   assign irq = irq_ff;

////////////////////////////////////////////////////////////////////////////
// Assertions

   a_ignore_enable: assert property (
      @(posedge clk) disable iff (vtr_por)
      (|(ev4 & ~en4_ff)) |=> ((sts4_ff & $past(ev4)) == $past(ev4)))
      else $error("Status missed event with enable clear");

   a_hold_set: assert property (
      @(posedge clk) disable iff (vtr_por)
      1'b1 |=> ((sts5_ff & $past(sts5_ff & ~clr5))
                == $past(sts5_ff & ~clr5)))
      else $error("Status bit dropped without clear");

   a_rst_keeps: assert property (
      @(posedge clk) disable iff (vtr_por)
      (sys_rst && !wr_fire) [*2] |=>
         ((sts4_ff & $past(sts4_ff)) == $past(sts4_ff)))
      else $error("Status lost during system reset");

   a_one_clears: assert property (
      @(posedge clk) disable iff (vtr_por)
      (wr_fire && idx == IDX_STS4) |=>
         ((sts4_ff & $past(wdat & ~ev4)) == 8'h00))
      else $error("Write one did not clear status");

   a_zero_keeps: assert property (
      @(posedge clk) disable iff (vtr_por)
      (wr_fire && idx == IDX_STS5) |=>
         ((sts5_ff & $past(sts5_ff & ~wdat))
          == $past(sts5_ff & ~wdat)))
      else $error("Write zero changed status");

   // Watch the second stage only; the first may be metastable
   a_map_four: assert property (
      @(posedge clk) disable iff (vtr_por)
      $rose(pin_s2_ff[5]) |=> sts4_ff[5])
      else $error("Port4 pin3 not mapped to bit 5");

   a_map_five: assert property (
      @(posedge clk) disable iff (vtr_por)
      pin_s2_ff[15] |=> sts5_ff[7])
      else $error("Port5 pin7 not mapped to bit 7");

   a_rsvd_zero: assert property (
      @(posedge clk) disable iff (sys_rst)
      (fire && !pwrite && idx == IDX_RSVD) |-> (prdata == 32'h0000_0000))
      else $error("Reserved offset read nonzero");

   a_wake_out: assert property (
      @(posedge clk) disable iff (vtr_por)
      (gen_ff && |({sts5_ff, sts4_ff} & {en5_ff, en4_ff}))
         |=> !wake_request_out_n)
      else $error("Wake request not asserted");

   a_wake_idle: assert property (
      @(posedge clk) disable iff (vtr_por)
      !gen_ff |=> wake_request_out_n)
      else $error("Wake request without global enable");

   a_set_wins: assert property (
      @(posedge clk) disable iff (vtr_por)
      (|(ev5 & clr5)) |=> ((sts5_ff & $past(ev5 & clr5))
                           == $past(ev5 & clr5)))
      else $error("Event lost against clear");

endmodule

// *** tb/tb_pws_bank.sv ***
// Testbench for the wake status bank: APB access, wake pins, outputs
`timescale 1ns/1ps

module tb_pws_bank
   import pws_pkg::*;
;
   localparam logic [7:0] A_STS4 = {IDX_STS4, 2'b00};
   localparam logic [7:0] A_STS5 = {IDX_STS5, 2'b00};
   localparam logic [7:0] A_RSVD = {IDX_RSVD, 2'b00};
   localparam logic [7:0] A_EN5 = {IDX_EN5, 2'b00};
   localparam logic [7:0] A_EN4 = {IDX_EN4, 2'b00};
   localparam logic [7:0] A_MSK4 = {IDX_IMSK4, 2'b00};
   localparam logic [7:0] A_GEN = {IDX_GEN, 2'b00};
   localparam logic [7:0] A_MSK5 = {IDX_IMSK5, 2'b00};
   logic clk = 1'b0;
   logic sys_rst, vtr_por, psel, penable, pwrite, pready, pslverr;
   logic wake_request_out_n, irq, last_err;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic [15:0] pins, exp_sts;
   int n_errors = 0;
   int tests_run = 0;

   ////////////////////////////////////////////////////////////////////////
   // Clock and design
   always #25 clk = ~clk;

   pws_bank dut (.clk(clk), .sys_rst(sys_rst), .vtr_por(vtr_por),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .port3_pin0(pins[0]), .port3_pin1(pins[1]),
      .port3_pin2(pins[2]), .port3_pin3(pins[3]), .port4_pin1(pins[4]),
      .port4_pin3(pins[5]), .port6_pin0(pins[6]), .port6_pin1(pins[7]),
      .port5_pin0(pins[8]), .port5_pin1(pins[9]), .port5_pin2(pins[10]),
      .port5_pin3(pins[11]), .port5_pin4(pins[12]), .port5_pin5(pins[13]),
      .port5_pin6(pins[14]), .port5_pin7(pins[15]),
      .wake_request_out_n(wake_request_out_n), .irq(irq));

   ////////////////////////////////////////////////////////////////////////
   // Verdict and comparison
   task automatic complete_run;
      if (n_errors == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] seen,
                      input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         $display("unexpected %s expected %h seen %h", name, exp, seen);
         n_errors++;
      end
   endtask

   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) n_errors++;
      rd = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rchk(input string name, input logic [7:0] a,
                       input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      chk(name, rd, {24'h000000, e});
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Watchdog
   initial begin
      #1000000;
      n_errors++;
      complete_run();
   end

   ////////////////////////////////////////////////////////////////////////
   // Test sequence
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      pstrb = 4'hF;
      pins = 16'h0000;
      vtr_por = 1'b1;
      sys_rst = 1'b1;
      exp_sts = 16'h0000;
      repeat (3) @(posedge clk);
      vtr_por <= 1'b0;
      sys_rst <= 1'b0;
      rchk("sts4 reset", A_STS4, 8'h00);
      rchk("sts5 reset", A_STS5, 8'h00);
      // Each pin alone, enables all off
      for (int i = 0; i < 16; i++) begin
         @(posedge clk);
         pins <= 16'h0001 << i;
         repeat (4) @(posedge clk);
         pins <= 16'h0000;
         exp_sts[i] = 1'b1;
         rchk("sts4 map", A_STS4, exp_sts[7:0]);
         rchk("sts5 map", A_STS5, exp_sts[15:8]);
      end
      apb(1'b1, A_STS4, 8'h00);
      rchk("sts4 zero write", A_STS4, 8'hFF);
      apb(1'b1, A_STS4, 8'h0F);
      rchk("sts4 clear", A_STS4, 8'hF0);
      apb(1'b1, A_STS5, 8'hA5);
      rchk("sts5 clear", A_STS5, 8'h5A);
      apb(1'b1, A_RSVD, 8'hFF);
      rchk("reserved", A_RSVD, 8'h00);
      chk("reserved err", {31'h0, last_err}, 32'h0);
      rchk("unmapped", 8'hFC, 8'h00);
      chk("unmapped err", {31'h0, last_err}, 32'h1);
      rchk("misaligned", 8'h1D, 8'h00);
      chk("misaligned err", {31'h0, last_err}, 32'h1);
      // Write with the low byte strobe off is ignored
      pstrb <= 4'hE;
      apb(1'b1, A_STS5, 8'hFF);
      pstrb <= 4'hF;
      rchk("sts5 strobe off", A_STS5, 8'h5A);
      // Soft reset keeps status
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      rchk("sts4 kept", A_STS4, 8'hF0);
      rchk("sts5 kept", A_STS5, 8'h5A);
      // Wake output and interrupt from port5 pin 0
      apb(1'b1, A_EN5, 8'h01);
      apb(1'b1, A_MSK5, 8'h01);
      apb(1'b1, A_GEN, 8'h01);
      // Port4 enables and masks miss the set status bits
      apb(1'b1, A_EN4, 8'h0F);
      apb(1'b1, A_MSK4, 8'h0F);
      rchk("en4", A_EN4, 8'h0F);
      rchk("msk4", A_MSK4, 8'h0F);
      rchk("en5", A_EN5, 8'h01);
      rchk("gen", A_GEN, 8'h01);
      repeat (2) @(posedge clk);
      chk("wake idle", {31'h0, wake_request_out_n}, 32'h1);
      chk("irq idle", {31'h0, irq}, 32'h0);
      pins <= 16'h0100;
      repeat (6) @(posedge clk);
      chk("wake on", {31'h0, wake_request_out_n}, 32'h0);
      chk("irq on", {31'h0, irq}, 32'h1);
      // Clear while the pin still holds the event
      apb(1'b1, A_STS5, 8'h01);
      rchk("set wins", A_STS5, 8'h5B);
      apb(1'b1, A_GEN, 8'h00);
      repeat (2) @(posedge clk);
      chk("wake global off", {31'h0, wake_request_out_n}, 32'h1);
      pins <= 16'h0000;
      repeat (4) @(posedge clk);
      apb(1'b1, A_STS5, 8'h01);
      repeat (2) @(posedge clk);
      chk("irq off", {31'h0, irq}, 32'h0);
      rchk("sts5 final", A_STS5, 8'h5A);
      complete_run();
   end
endmodule
